//--- logic/btm_defs.vh
`ifndef BTM_DEFS_VH
`define BTM_DEFS_VH

// register byte offsets
`define BTM_OFF_CTRL      8'h00
`define BTM_OFF_STATUS    8'h04
`define BTM_OFF_SLOT      8'h08
`define BTM_OFF_ID        8'h0C
`define BTM_OFF_CYC_LO    8'h10
`define BTM_OFF_CYC_HI    8'h14
`define BTM_OFF_RDB_LO    8'h18
`define BTM_OFF_RDB_HI    8'h1C
`define BTM_OFF_WRB_LO    8'h20
`define BTM_OFF_WRB_HI    8'h24
`define BTM_OFF_RDQ_LO    8'h28
`define BTM_OFF_RDQ_HI    8'h2C
`define BTM_OFF_WRQ_LO    8'h30
`define BTM_OFF_WRQ_HI    8'h34
`define BTM_OFF_WRS_LO    8'h38
`define BTM_OFF_WRS_HI    8'h3C

// control register fields
`define BTM_CTRL_START    0
`define BTM_CTRL_STOP     1
`define BTM_CTRL_CLEAR    2
`define BTM_CTRL_WIDE     3

// status register fields
`define BTM_STAT_RUN      0
`define BTM_STAT_DONE     1

// reset values
`define BTM_SLOT_RST      2'h0
`define BTM_WIDE_RST      1'h0

// axi responses
`define BTM_RESP_OKAY     2'h0
`define BTM_RESP_SLVERR   2'h2

`endif

//--- logic/btm_counter.v
`timescale 1ns/10ps
`default_nettype none

// one metric counter, 64 bits, wraps at 32 bits in narrow mode
module btm_counter #(
    parameter INC_W = 8
) (
    input  wire             clk,
    input  wire             rst_b,
    input  wire             clear,
    input  wire             run,
    input  wire             wide,
    input  wire [INC_W-1:0] inc,
    output wire [63:0]      count
);
    reg  [63:0] cnt_r;   // accumulated value
    reg  [63:0] cnt_nxt; // next value
    reg  [63:0] sum;     // full 64-bit sum

    // add only while the window is open; narrow mode keeps upper half at zero
    always @* begin
        sum     = cnt_r + {{(64-INC_W){1'b0}}, inc};
        cnt_nxt = cnt_r;
        if (clear) begin
            cnt_nxt = 64'h0;
        end else if (run) begin
            cnt_nxt = wide ? sum : {32'h0, sum[31:0]};
        end
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            cnt_r <= 64'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign count = cnt_r;
endmodule

`default_nettype wire

//--- logic/btm_monitor.v
// Function
// - monitor never drives or stalls watched channels
// - observe only memory slave read/write channels
// - four attachment slots, one selected
// - count read/write bytes, requests, write responses
// - processor writes start and stop commands
// - cycle counter runs from start to stop
// - counters selectable as 32 or 64 bits
// - final counts readable over register port
// - count only completed valid/ready handshakes
// - all registers reached over AXI4-Lite slave
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "btm_defs.vh"

module btm_monitor #(
    parameter NSLOT  = 4,             // attachment slots
    parameter DATA_W = 256,           // monitored data width
    parameter [31:0] ID_VALUE = 32'h00C0FFEE // arbitrary identity value
) (
    input  wire                     REF_CLK,
    input  wire                     RST_B,
    // monitored slots, flattened, inputs only; nothing is ever driven back
    input  wire [NSLOT-1:0]         MON_ARVALID,
    input  wire [NSLOT-1:0]         MON_ARREADY,
    input  wire [NSLOT-1:0]         MON_RVALID,
    input  wire [NSLOT-1:0]         MON_RREADY,
    input  wire [NSLOT-1:0]         MON_AWVALID,
    input  wire [NSLOT-1:0]         MON_AWREADY,
    input  wire [NSLOT-1:0]         MON_WVALID,
    input  wire [NSLOT-1:0]         MON_WREADY,
    input  wire [NSLOT*DATA_W/8-1:0] MON_WSTRB,
    input  wire [NSLOT-1:0]         MON_BVALID,
    input  wire [NSLOT-1:0]         MON_BREADY,
    // axi4-lite register slave
    input  wire [7:0]               S_AXI_AWADDR,
    input  wire                     S_AXI_AWVALID,
    output reg                      S_AXI_AWREADY,
    input  wire [31:0]              S_AXI_WDATA,
    input  wire [3:0]               S_AXI_WSTRB,
    input  wire                     S_AXI_WVALID,
    output reg                      S_AXI_WREADY,
    output reg  [1:0]               S_AXI_BRESP,
    output reg                      S_AXI_BVALID,
    input  wire                     S_AXI_BREADY,
    input  wire [7:0]               S_AXI_ARADDR,
    input  wire                     S_AXI_ARVALID,
    output reg                      S_AXI_ARREADY,
    output reg  [31:0]              S_AXI_RDATA,
    output reg  [1:0]               S_AXI_RRESP,
    output reg                      S_AXI_RVALID,
    input  wire                     S_AXI_RREADY
);
    localparam SW    = DATA_W/8;   // strobe bits per beat
    localparam BW    = 8;          // width of a byte increment
    localparam BYTES = 8'd32;      // bytes per full read beat (no narrow bursts)

    // population count of one strobe word
    function [BW-1:0] popcnt;
        input [SW-1:0] s;
        integer i;
        begin
            popcnt = {BW{1'b0}};
            for (i = 0; i < SW; i = i + 1) begin
                popcnt = popcnt + {{(BW-1){1'b0}}, s[i]};
            end
        end
    endfunction

    // control state
    reg         run_r;       // measurement window open
    reg         done_r;      // window closed by stop
    reg         wide_r;      // 64-bit counters
    reg  [1:0]  slot_r;      // selected slot
    reg         clear_r;     // one-cycle clear pulse
    // write channel capture, either order
    reg         aw_got_r;
    reg         w_got_r;
    reg  [7:0]  aw_addr_r;
    reg  [31:0] w_data_r;
    reg  [3:0]  w_strb_r;

    // selected slot handshakes, registered once to ease timing;
    // monitored inputs share REF_CLK so no synchroniser is needed
    reg         ev_ar_r, ev_r_r, ev_aw_r, ev_w_r, ev_b_r;
    reg  [SW-1:0] ev_strb_r;

    // sample the chosen slot; pure observation, nothing is driven back
    always @(posedge REF_CLK) begin
        if (!RST_B) begin
            ev_ar_r   <= 1'b0;
            ev_r_r    <= 1'b0;
            ev_aw_r   <= 1'b0;
            ev_w_r    <= 1'b0;
            ev_b_r    <= 1'b0;
            ev_strb_r <= {SW{1'b0}};
        end else begin
            ev_ar_r   <= MON_ARVALID[slot_r] & MON_ARREADY[slot_r];
            ev_r_r    <= MON_RVALID[slot_r]  & MON_RREADY[slot_r];
            ev_aw_r   <= MON_AWVALID[slot_r] & MON_AWREADY[slot_r];
            ev_w_r    <= MON_WVALID[slot_r]  & MON_WREADY[slot_r];
            ev_b_r    <= MON_BVALID[slot_r]  & MON_BREADY[slot_r];
            ev_strb_r <= MON_WSTRB[slot_r*SW +: SW];
        end
    end

    // per-event increments
    wire [BW-1:0] inc_rdb = ev_r_r ? BYTES : {BW{1'b0}};
    wire [BW-1:0] inc_wrb = ev_w_r ? popcnt(ev_strb_r) : {BW{1'b0}};
    wire [63:0]   cyc, rdb, wrb, rdq, wrq, wrs;

    // cycle counter: one per core clock inside window
    btm_counter #(.INC_W(1)) u_cyc (.clk(REF_CLK), .rst_b(RST_B), .clear(clear_r), .run(run_r),
        .wide(wide_r), .inc(1'b1), .count(cyc));
    btm_counter #(.INC_W(BW)) u_rdb (.clk(REF_CLK), .rst_b(RST_B), .clear(clear_r), .run(run_r),
        .wide(wide_r), .inc(inc_rdb), .count(rdb));
    btm_counter #(.INC_W(BW)) u_wrb (.clk(REF_CLK), .rst_b(RST_B), .clear(clear_r), .run(run_r),
        .wide(wide_r), .inc(inc_wrb), .count(wrb));
    btm_counter #(.INC_W(1)) u_rdq (.clk(REF_CLK), .rst_b(RST_B), .clear(clear_r), .run(run_r),
        .wide(wide_r), .inc(ev_ar_r), .count(rdq));
    btm_counter #(.INC_W(1)) u_wrq (.clk(REF_CLK), .rst_b(RST_B), .clear(clear_r), .run(run_r),
        .wide(wide_r), .inc(ev_aw_r), .count(wrq));
    btm_counter #(.INC_W(1)) u_wrs (.clk(REF_CLK), .rst_b(RST_B), .clear(clear_r), .run(run_r),
        .wide(wide_r), .inc(ev_b_r), .count(wrs));

    // write commit happens when both halves are held and no response pending
    wire wr_fire = aw_got_r & w_got_r & ~S_AXI_BVALID;
    wire wr_map  = (aw_addr_r[7:2] <= 6'h0F) && (aw_addr_r[1:0] == 2'b00);

    // axi write channel: accept address and data independently
    always @(posedge REF_CLK) begin
        if (!RST_B) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= `BTM_RESP_OKAY;
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            aw_addr_r     <= 8'h00;
            w_data_r      <= 32'h0;
            w_strb_r      <= 4'h0;
        end else begin
            // ready offered for one cycle while the half is still missing
            S_AXI_AWREADY <= ~aw_got_r & S_AXI_AWVALID & ~S_AXI_AWREADY;
            S_AXI_WREADY  <= ~w_got_r & S_AXI_WVALID & ~S_AXI_WREADY;
            if (S_AXI_AWVALID & S_AXI_AWREADY) begin
                aw_got_r  <= 1'b1;
                aw_addr_r <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID & S_AXI_WREADY) begin
                w_got_r  <= 1'b1;
                w_data_r <= S_AXI_WDATA;
                w_strb_r <= S_AXI_WSTRB;
            end
            if (wr_fire) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= wr_map ? `BTM_RESP_OKAY : `BTM_RESP_SLVERR;
            end else if (S_AXI_BVALID & S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // control register effects: start opens, stop closes, clear zeroes
    always @(posedge REF_CLK) begin
        if (!RST_B) begin
            run_r   <= 1'b0;
            done_r  <= 1'b0;
            wide_r  <= `BTM_WIDE_RST;
            slot_r  <= `BTM_SLOT_RST;
            clear_r <= 1'b0;
        end else begin
            clear_r <= 1'b0;
            if (wr_fire && w_strb_r[0]) begin
                if (aw_addr_r == `BTM_OFF_CTRL) begin
                    wide_r <= w_data_r[`BTM_CTRL_WIDE];
                    if (w_data_r[`BTM_CTRL_CLEAR]) begin
                        clear_r <= 1'b1;
                        done_r  <= 1'b0;
                    end
                    // stop wins over start written together
                    if (w_data_r[`BTM_CTRL_STOP]) begin
                        run_r  <= 1'b0;
                        done_r <= run_r;
                    end else if (w_data_r[`BTM_CTRL_START]) begin
                        run_r  <= 1'b1;
                        done_r <= 1'b0;
                    end
                end else if (aw_addr_r == `BTM_OFF_SLOT) begin
                    // changing the slot mid-window mixes sources; software should not
                    slot_r <= w_data_r[1:0];
                end
            end
        end
    end

    // read mux of counter halves and status
    reg [31:0] rd_val;
    reg        rd_ok;
    always @* begin
        rd_ok = 1'b1;
        case (S_AXI_ARADDR)
            `BTM_OFF_CTRL:   rd_val = {28'h0, wide_r, 2'b00, run_r};
            `BTM_OFF_STATUS: rd_val = {30'h0, done_r, run_r};
            `BTM_OFF_SLOT:   rd_val = {30'h0, slot_r};
            `BTM_OFF_ID:     rd_val = ID_VALUE;
            `BTM_OFF_CYC_LO: rd_val = cyc[31:0];
            `BTM_OFF_CYC_HI: rd_val = cyc[63:32];
            `BTM_OFF_RDB_LO: rd_val = rdb[31:0];
            `BTM_OFF_RDB_HI: rd_val = rdb[63:32];
            `BTM_OFF_WRB_LO: rd_val = wrb[31:0];
            `BTM_OFF_WRB_HI: rd_val = wrb[63:32];
            `BTM_OFF_RDQ_LO: rd_val = rdq[31:0];
            `BTM_OFF_RDQ_HI: rd_val = rdq[63:32];
            `BTM_OFF_WRQ_LO: rd_val = wrq[31:0];
            `BTM_OFF_WRQ_HI: rd_val = wrq[63:32];
            `BTM_OFF_WRS_LO: rd_val = wrs[31:0];
            `BTM_OFF_WRS_HI: rd_val = wrs[63:32];
            default: begin
                rd_val = 32'h0;
                rd_ok  = 1'b0;
            end
        endcase
    end

    // axi read channel: one-cycle ready, data the cycle after
    always @(posedge REF_CLK) begin
        if (!RST_B) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0;
            S_AXI_RRESP   <= `BTM_RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= S_AXI_ARVALID & ~S_AXI_ARREADY & ~S_AXI_RVALID;
            if (S_AXI_ARVALID & S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA  <= rd_val;
                S_AXI_RRESP  <= rd_ok ? `BTM_RESP_OKAY : `BTM_RESP_SLVERR;
            end else if (S_AXI_RVALID & S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

//--- tb/btm_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "btm_defs.vh"
// register-slave checks; the watched channels are inputs only, so only the slave side is checked here
module btm_assertions (
    input wire logic        REF_CLK,
    input wire logic        RST_B,
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic [1:0]  S_AXI_BRESP,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic [7:0]  S_AXI_ARADDR,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0]  S_AXI_RRESP,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    AST_AW_CAUSE: assert property (S_AXI_AWREADY |-> S_AXI_AWVALID) else $error("awready without awvalid");
    AST_AR_CAUSE: assert property (S_AXI_ARREADY |-> S_AXI_ARVALID) else $error("arready without arvalid");
    AST_B_AFTER: assert property (S_AXI_WVALID && S_AXI_WREADY |-> ##[1:4] S_AXI_BVALID)
        else $error("no bvalid");
    AST_R_AFTER: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("no rvalid");
    // a response must not move while the master is stalling it
    AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read response dropped");
    AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped");
    AST_R_ERR: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > `BTM_OFF_WRS_HI
        |=> S_AXI_RRESP == `BTM_RESP_SLVERR && S_AXI_RDATA == 32'h0) else $error("unmapped read");
    AST_R_ONE: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID) else $error("rvalid held");
    AST_RST_QUIET: assert property ($rose(RST_B) |-> !S_AXI_BVALID && !S_AXI_RVALID)
        else $error("busy at reset");
endmodule
bind btm_monitor btm_assertions u_chk (.REF_CLK(REF_CLK), .RST_B(RST_B), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));
`default_nettype wire

//--- tb/btm_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// memory slave plus interconnect as seen by one monitor slot
module btm_mem_model (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        go,
    input  wire logic [3:0]  cnt,
    input  wire logic        slow,
    input  wire logic [31:0] strb,
    output var  logic [4:0]  vld,
    output var  logic [4:0]  rdy,
    output var  logic        busy,
    output wire logic [31:0] wstrb
);
    // idle strobes show the inverse, so stale lanes never count by luck
    assign wstrb = vld[3] ? strb : ~strb;
    // one handshake on channel c: 0 ar, 1 r, 2 aw, 3 w, 4 b
    task automatic beat(input int c);
        vld[c] <= 1'b1;
        if (slow) @(posedge clk); // valid waits on a stalled ready
        rdy[c] <= 1'b1;
        @(posedge clk);
        vld[c] <= 1'b0;
        rdy[c] <= 1'b0;
    endtask
    // each transaction: address and beat for read, then write, then response
    always @(posedge clk) begin
        if (!rst_b) begin
            vld <= '0;
            rdy <= '0;
            busy <= 1'b0;
        end else if (go) begin
            busy <= 1'b1;
            for (int t = 0; t < cnt; t++) for (int c = 0; c < 5; c++) beat(c);
            busy <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "btm_defs.vh"
module testbench;
    localparam logic [31:0] C_GO = 32'h1 << `BTM_CTRL_START;
    localparam logic [31:0] C_STOP = 32'h1 << `BTM_CTRL_STOP;
    localparam logic [31:0] C_CLR = 32'h1 << `BTM_CTRL_CLEAR;
    logic        clk = 1'b0, rst_b = 1'b0, go = 1'b0, slow = 1'b0;
    logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic [7:0]  awa = '0, ara = '0;
    logic [31:0] wd = '0, strb = '0;
    logic [3:0]  cnt = '0;
    logic [1:0]  ts = '0;
    wire  logic  aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, busy;
    wire  logic [1:0] b_resp, r_resp;
    wire  logic [31:0] r_dat, ws;
    wire  logic [4:0] vl, ry;
    int err_count = 0;
    int n_checks = 0;
    always #2 clk = ~clk;
    btm_mem_model u_mem (.clk(clk), .rst_b(rst_b), .go(go), .cnt(cnt), .slow(slow), .strb(strb),
        .vld(vl), .rdy(ry), .busy(busy), .wstrb(ws));
    // model traffic is steered onto slot ts only
    btm_monitor uut (.REF_CLK(clk), .RST_B(rst_b), .MON_ARVALID(4'(vl[0]) << ts), .MON_ARREADY(4'(ry[0]) << ts),
        .MON_RVALID(4'(vl[1]) << ts), .MON_RREADY(4'(ry[1]) << ts), .MON_AWVALID(4'(vl[2]) << ts),
        .MON_AWREADY(4'(ry[2]) << ts), .MON_WVALID(4'(vl[3]) << ts), .MON_WREADY(4'(ry[3]) << ts),
        .MON_WSTRB(128'(ws) << (ts * 32)), .MON_BVALID(4'(vl[4]) << ts), .MON_BREADY(4'(ry[4]) << ts),
        .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(aw_rdy), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(w_rdy), .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_vld), .S_AXI_BREADY(bry),
        .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(ar_rdy), .S_AXI_RDATA(r_dat),
        .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_vld), .S_AXI_RREADY(rry));
    task automatic tally_and_finish;
        if (err_count == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %0h got %0h", nm, e, g);
        end
    endtask
    // write: address and data offered together; bready raised a cycle late to stall the response
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            if (aw_rdy) awv <= 1'b0;
            if (w_rdy) wv <= 1'b0;
            if (b_vld && bry) begin
                r = b_resp; bry <= 1'b0; @(posedge clk); return;
            end
            if (b_vld) bry <= 1'b1;
        end
        err_count++;
        tally_and_finish();
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        ara <= a; arv <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            if (ar_rdy) arv <= 1'b0;
            if (r_vld && rry) begin
                d = r_dat; r = r_resp; rry <= 1'b0; @(posedge clk); return;
            end
            if (r_vld) rry <= 1'b1;
        end
        err_count++;
        tally_and_finish();
    endtask
    task automatic ctl(input logic [31:0] d);
        logic [1:0] r;
        axw(`BTM_OFF_CTRL, d, r);
        chk("ctrl bresp", `BTM_RESP_OKAY, r);
    endtask
    // counters are read low word then high word
    task automatic rd64(input logic [7:0] a, output logic [63:0] v);
        logic [1:0] r;
        axr(a, v[31:0], r);
        axr(a + 8'h04, v[63:32], r);
    endtask
    // one measured run of k transactions on slot t while slot sl is selected
    task automatic meas(input logic [1:0] sl, t, input logic [3:0] k, input logic s, w, input logic [31:0] sb);
        logic [63:0] v, e;
        logic [63:0] ex [5];
        logic [31:0] wb;
        logic [1:0] r;
        wb = 32'(w) << `BTM_CTRL_WIDE;
        axw(`BTM_OFF_SLOT, 32'(sl), r);
        ctl(C_CLR | wb);
        ctl(C_GO | wb);
        axr(`BTM_OFF_STATUS, v[31:0], r);
        chk("running", 64'h1, 64'(v[0]));
        axr(`BTM_OFF_CTRL, v[31:0], r);
        chk("ctrl wide", 64'(w), 64'(v[`BTM_CTRL_WIDE]));
        ts <= t; cnt <= k; slow <= s; strb <= sb; go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 400 && busy; i++) @(posedge clk);
        if (busy) begin
            err_count++;
            tally_and_finish();
        end
        ctl(C_STOP | wb);
        axr(`BTM_OFF_STATUS, v[31:0], r);
        chk("done", 64'h2, 64'(v[1:0]));
        e = (sl == t) ? 64'(k) : 64'h0;
        ex = '{e * 32, e * $countones(sb), e, e, e};
        for (int j = 0; j < 5; j++) begin
            rd64(`BTM_OFF_RDB_LO + 8'(8 * j), v);
            chk("metric", ex[j], v);
        end
    endtask
    task automatic cyc(input int k, output logic [63:0] c);
        ctl(C_CLR);
        ctl(C_GO);
        repeat (k) @(posedge clk);
        ctl(C_STOP);
        rd64(`BTM_OFF_CYC_LO, c);
    endtask
    initial begin
        logic [63:0] c1, c2;
        logic [31:0] v;
        logic [1:0] r;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        axr(`BTM_OFF_SLOT, v, r);
        chk("slot reset", 64'(`BTM_SLOT_RST), 64'(v));
        axr(8'h40, v, r);
        chk("unmapped rresp", 64'(`BTM_RESP_SLVERR), 64'(r));
        chk("unmapped rdata", 64'h0, 64'(v));
        axw(8'h44, 32'h0, r);
        chk("unmapped bresp", 64'(`BTM_RESP_SLVERR), 64'(r));
        meas(2'd0, 2'd0, 4'd3, 1'b0, 1'b0, 32'hFFFFFFFF);
        meas(2'd1, 2'd1, 4'd4, 1'b1, 1'b1, 32'h0000F00F);
        meas(2'd2, 2'd2, 4'd1, 1'b1, 1'b0, 32'h00000001);
        meas(2'd3, 2'd3, 4'd2, 1'b0, 1'b1, 32'h80000000);
        meas(2'd2, 2'd1, 4'd2, 1'b1, 1'b0, 32'hFFFF0000);
        cyc(10, c1);
        cyc(110, c2);
        chk("cycle delta", 64'd100, c2 - c1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
